/* hdl/ttc_defines.svh */
// register offsets, bit positions, reset values and rate counts of the timer unit
`ifndef TTC_DEFINES_SVH
`define TTC_DEFINES_SVH
`define TTC_A_CTRL01   8'h88
`define TTC_A_MODE01   8'h89
`define TTC_A_TL0      8'h8A
`define TTC_A_TL1      8'h8B
`define TTC_A_TH0      8'h8C
`define TTC_A_TH1      8'h8D
`define TTC_A_RATE     8'h8F
`define TTC_A_CTRL2    8'hC8
`define TTC_A_CAPL     8'hCA
`define TTC_A_CAPH     8'hCB
`define TTC_A_TL2      8'hCC
`define TTC_A_TH2      8'hCD
// control register 01 bits
`define TTC_B_TF1      7
`define TTC_B_TR1      6
`define TTC_B_TF0      5
`define TTC_B_TR0      4
`define TTC_B_IE1      3
`define TTC_B_IT1      2
`define TTC_B_IE0      1
`define TTC_B_IT0      0
// mode register: channel 1 in the high nibble, channel 0 in the low
`define TTC_B_GATE     3
`define TTC_B_CT       2
`define TTC_B_MODE     0
// channel 2 control bits
`define TTC_B_TF2      7
`define TTC_B_CH2_EXTERNAL_FLAG     6
`define TTC_B_RCLK     5
`define TTC_B_TX_BITCLOCK_SELECT     4
`define TTC_B_CH2_EXTERNAL_ENABLE    3
`define TTC_B_TR2      2
`define TTC_B_CT2      1
`define TTC_B_CPRL2    0
// rate control bits
`define TTC_B_T0M      3
`define TTC_B_T1M      4
`define TTC_B_T2M      5
`define TTC_RESET      8'h00
// clocks per machine cycle, per fast tick and per baud tick
`define TTC_MC_CLKS    4'hC
`define TTC_FAST_CLKS  4'h4
`define TTC_BAUD_CLKS  4'h2
`endif

/* hdl/ttc_pkg.sv */
// types shared by the timer unit
package ttc_pkg;
  typedef enum logic [1:0] {TTC_M13, TTC_M16, TTC_M8R, TTC_MSPLIT} ttc_mode_type;
endpackage : ttc_pkg

/* hdl/ttc_unit.sv */
// triple timer/counter unit with external interrupt detectors
// Notes on behaviour
// - channels 0/1 set overflow flag on overflow (channel 1 not while channel 0 is in mode 11); cleared when the core vectors
// - channels 0/1 count only while their run bit is 1; in mode 11 the channel 0 high byte uses the channel 1 run bit
// - edge mode: falling pin edge sets request; cleared on vectoring or software
// - level mode: request follows pin low; software writes ignored
// - type bit 1 detects falling edge, 0 detects low level
// - gate 1: count only while irq pin high and run bit set
// - select bit: 0 counts clock/12 (clock/4 with rate bit set), 1 counts external count pin
// - mode 00 13-bit, 01 16-bit, 10 8-bit reload; channel 1 mode 11 off
// - channel 0 mode 11 splits into two 8-bit counters
// - mode 0: high byte counter behind 5-bit low-byte prescaler
// - 8-bit reload: low byte overflow reloads it from high byte
// - channel 2 overflow flag set from FFFF only when both clock selects 0
// - channel 2 external flag set by trigger edge with external enable
// - rx/tx clock selects pick channel 2 (1) or channel 1 (0) overflow
// - trigger edge with external enable captures/reloads unless baud mode
// - channel 2 runs while its run bit is 1
// - channel 2 select: 0 internal timing, 1 counts count-pin falls
// - channel 2 timer ticks every 4 or 12 clocks; baud mode every 2
// - capture bit 1 captures on trigger; 0 reloads on overflow and trigger
// - any clock select set forces reload after every overflow
// - count pin sampled once per machine cycle; high then low increments
// - timer function increments once per machine cycle, or every 4 clocks with its rate bit set
// - capture copies count bytes into capture registers
// - reload loads the 16-bit capture/reload pair into the counter
// - baud mode: no overflow flag; trigger sets external flag only
`timescale 1ns/1ps
`include "ttc_defines.svh"
module ttc_unit (
  input  wire logic       core_clk,      // 250 MHz clock
  input  wire logic       rst,           // synchronous reset
  input  wire logic [7:0] sfr_addr,      // register address
  input  wire logic       sfr_wr,        // write strobe
  input  wire logic       sfr_rd,        // read strobe
  input  wire logic [7:0] sfr_wdata,     // write data
  output logic      [7:0] sfr_rdata,     // read data, one cycle after strobe
  input  wire logic       ext_irq0_pin,  // external interrupt 0, low active
  input  wire logic       ext_irq1_pin,  // external interrupt 1, low active
  input  wire logic       ch0_count_pin, // channel 0 count input
  input  wire logic       ch1_count_pin, // channel 1 count input
  input  wire logic       ch2_count_pin, // channel 2 count input
  input  wire logic       ch2_trigger_pin, // channel 2 trigger input
  input  wire logic       ack_ext0,      // vector taken, external 0
  input  wire logic       ack_ch0,       // vector taken, channel 0
  input  wire logic       ack_ext1,      // vector taken, external 1
  input  wire logic       ack_ch1,       // vector taken, channel 1
  output logic            irq_ext0,      // request external 0
  output logic            irq_ch0,       // request channel 0
  output logic            irq_ext1,      // request external 1
  output logic            irq_ch1,       // request channel 1
  output logic            irq_ch2,       // request channel 2
  output logic            rx_bitclk_tick, // receive bit clock pulse
  output logic            tx_bitclk_tick  // transmit bit clock pulse
);

  // one count step of channel 0/1 low/high bytes: returns {ovf, th, tl}
  function automatic logic [16:0] ttc_step(input logic [7:0] tl, input logic [7:0] th,
                                            input logic [1:0] m, input logic inc);
    logic [16:0] r;
    r = {1'b0, th, tl};
    if (inc) begin
      unique case (ttc_pkg::ttc_mode_type'(m))
        ttc_pkg::TTC_M13: begin
          r[4:0] = tl[4:0] + 5'h01;
          if (tl[4:0] == 5'h1F) begin
            r[15:8] = th + 8'h01;
            r[16]   = (th == 8'hFF);
          end
        end
        ttc_pkg::TTC_M16: r = {1'b0, th, tl} + 17'h00001;
        ttc_pkg::TTC_M8R: begin
          r[7:0] = (tl == 8'hFF) ? th : tl + 8'h01;
          r[16]  = (tl == 8'hFF);
        end
        ttc_pkg::TTC_MSPLIT: begin
          r[7:0] = tl + 8'h01;
          r[16]  = (tl == 8'hFF);
        end
      endcase
    end
    return r;
  endfunction : ttc_step

  // divider and pin synchronisers
  logic [3:0] div, next_div;
  logic [5:0] sy1, sy2, smp, next_smp, prev, next_prev;
  always_comb begin
    next_div  = (div == `TTC_MC_CLKS - 4'h1) ? 4'h0 : div + 4'h1;
    next_smp  = smp;
    next_prev = sy2;
    if (div == `TTC_MC_CLKS - 4'h1) begin
      next_smp = sy2;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div  <= 4'h0;
      sy1  <= 6'h3F;
      sy2  <= 6'h3F;
      smp  <= 6'h3F;
      prev <= 6'h3F;
    end else begin
      div  <= next_div;
      sy1  <= {ch2_trigger_pin, ch2_count_pin, ch1_count_pin, ch0_count_pin,
               ext_irq1_pin, ext_irq0_pin};
      sy2  <= sy1;
      smp  <= next_smp;
      prev <= next_prev;
    end
  end

  // rate ticks and pin events
  logic tick12, tick4, tick2, mc_end;
  logic [5:0] mc_fall;
  logic ext_irq0_pin_fall, ext_irq1_pin_fall, trig_fall;
  assign mc_end    = (div == `TTC_MC_CLKS - 4'h1);
  assign tick12    = mc_end;
  assign tick4     = (div[1:0] == 2'(`TTC_FAST_CLKS - 4'h1));
  assign tick2     = div[0] == 1'(`TTC_BAUD_CLKS - 4'h1);
  assign mc_fall   = mc_end ? (smp & ~sy2) : 6'h00;
  assign ext_irq0_pin_fall = prev[0] & ~sy2[0];
  assign ext_irq1_pin_fall = prev[1] & ~sy2[1];
  assign trig_fall = prev[5] & ~sy2[5];

  // register state
  logic [7:0] ctl01, mod01, tl0, th0, tl1, th1, rate, ctl2, capl, caph, tl2, th2;
  logic [7:0] n_ctl01, n_tl0, n_th0, n_tl1, n_th1, n_ctl2, n_capl, n_caph, n_tl2, n_th2;
  logic [7:0] n_rdata;
  logic [16:0] s0, s1, s0h;
  logic run0, run1, run0h, inc0, inc1, inc0h, src0, src1;
  logic baud, rate2, inc2, ovf2, trig2, ovf1_tick;
  logic [16:0] c2;
  logic wr01, wr2;

  // channel 0/1 increment conditions
  always_comb begin
    run0  = ctl01[`TTC_B_TR0] & (~mod01[`TTC_B_GATE] | sy2[0]);
    run1  = ctl01[`TTC_B_TR1] & (~mod01[4+`TTC_B_GATE] | sy2[1]);
    src0  = mod01[`TTC_B_CT] ? mc_fall[2]
          : (rate[`TTC_B_T0M] ? tick4 : tick12);
    src1  = mod01[4+`TTC_B_CT] ? mc_fall[3]
          : (rate[`TTC_B_T1M] ? tick4 : tick12);
    inc0  = run0 & src0;
    inc1  = run1 & src1 & (mod01[5:4] != 2'h3);
    run0h = ctl01[`TTC_B_TR1];
    inc0h = run0h & (rate[`TTC_B_T0M] ? tick4 : tick12) & (mod01[1:0] == 2'h3);
    s0    = ttc_step(tl0, th0, mod01[1:0], inc0);
    s1    = ttc_step(tl1, th1, mod01[5:4], inc1);
    s0h   = {(th0 == 8'hFF) & inc0h, th0 + {7'h00, inc0h}, 8'h00};
  end

  // channel 2 conditions
  always_comb begin
    baud  = ctl2[`TTC_B_RCLK] | ctl2[`TTC_B_TX_BITCLOCK_SELECT];
    rate2 = baud ? tick2 : (rate[`TTC_B_T2M] ? tick4 : tick12);
    inc2  = ctl2[`TTC_B_TR2] & (ctl2[`TTC_B_CT2] ? mc_fall[4] : rate2);
    ovf2  = inc2 & ({th2, tl2} == 16'hFFFF);
    trig2 = trig_fall & ctl2[`TTC_B_CH2_EXTERNAL_ENABLE];
    c2    = {1'b0, th2, tl2} + {16'h0000, inc2};
    if ((ovf2 & (~ctl2[`TTC_B_CPRL2] | baud)) |
        (trig2 & ~ctl2[`TTC_B_CPRL2] & ~baud)) begin
      c2 = {1'b0, caph, capl};
    end
  end

  // next register values; software data writes win over counting
  always_comb begin
    wr01    = sfr_wr & (sfr_addr == `TTC_A_CTRL01);
    wr2     = sfr_wr & (sfr_addr == `TTC_A_CTRL2);
    n_ctl01 = wr01 ? sfr_wdata : ctl01;
    n_tl0   = s0[7:0];
    n_th0   = (mod01[1:0] == 2'h3) ? s0h[15:8] : s0[15:8];
    n_tl1   = s1[7:0];
    n_th1   = s1[15:8];
    n_ctl2  = wr2 ? sfr_wdata : ctl2;
    n_capl  = capl;
    n_caph  = caph;
    n_tl2   = c2[7:0];
    n_th2   = c2[15:8];
    // overflow flags: software write, vector clear, hardware set wins
    if (ack_ch0) n_ctl01[`TTC_B_TF0] = 1'b0;
    if (ack_ch1) n_ctl01[`TTC_B_TF1] = 1'b0;
    if (s0[16]) n_ctl01[`TTC_B_TF0] = 1'b1;
    if ((s1[16] & (mod01[1:0] != 2'h3)) | s0h[16]) n_ctl01[`TTC_B_TF1] = 1'b1;
    // external interrupt 0 request
    if (ctl01[`TTC_B_IT0]) begin
      if (ack_ext0) n_ctl01[`TTC_B_IE0] = 1'b0;
      if (ext_irq0_pin_fall) n_ctl01[`TTC_B_IE0] = 1'b1;
    end else begin
      n_ctl01[`TTC_B_IE0] = ~sy2[0];
    end
    // external interrupt 1 request
    if (ctl01[`TTC_B_IT1]) begin
      if (ack_ext1) n_ctl01[`TTC_B_IE1] = 1'b0;
      if (ext_irq1_pin_fall) n_ctl01[`TTC_B_IE1] = 1'b1;
    end else begin
      n_ctl01[`TTC_B_IE1] = ~sy2[1];
    end
    // channel 2 flags: software may write, hardware set wins
    if (ovf2 & ~baud) n_ctl2[`TTC_B_TF2] = 1'b1;
    if (trig2) n_ctl2[`TTC_B_CH2_EXTERNAL_FLAG] = 1'b1;
    if (trig2 & ctl2[`TTC_B_CPRL2] & ~baud) begin
      n_capl = tl2;
      n_caph = th2;
    end
    // data register writes
    unique case (sfr_wr ? sfr_addr : 8'h00)
      `TTC_A_TL0:  n_tl0  = sfr_wdata;
      `TTC_A_TH0:  n_th0  = sfr_wdata;
      `TTC_A_TL1:  n_tl1  = sfr_wdata;
      `TTC_A_TH1:  n_th1  = sfr_wdata;
      `TTC_A_CAPL: n_capl = sfr_wdata;
      `TTC_A_CAPH: n_caph = sfr_wdata;
      `TTC_A_TL2:  n_tl2  = sfr_wdata;
      `TTC_A_TH2:  n_th2  = sfr_wdata;
      default: ;
    endcase
    // read data, unmapped addresses read zero
    unique case (sfr_addr)
      `TTC_A_CTRL01: n_rdata = ctl01;
      `TTC_A_MODE01: n_rdata = mod01;
      `TTC_A_TL0:    n_rdata = tl0;
      `TTC_A_TL1:    n_rdata = tl1;
      `TTC_A_TH0:    n_rdata = th0;
      `TTC_A_TH1:    n_rdata = th1;
      `TTC_A_RATE:   n_rdata = rate;
      `TTC_A_CTRL2:  n_rdata = ctl2;
      `TTC_A_CAPL:   n_rdata = capl;
      `TTC_A_CAPH:   n_rdata = caph;
      `TTC_A_TL2:    n_rdata = tl2;
      `TTC_A_TH2:    n_rdata = th2;
      default:       n_rdata = 8'h00;
    endcase
    if (!sfr_rd) n_rdata = sfr_rdata;
  end

  // register all state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl01     <= `TTC_RESET;
      mod01     <= `TTC_RESET;
      tl0       <= `TTC_RESET;
      th0       <= `TTC_RESET;
      tl1       <= `TTC_RESET;
      th1       <= `TTC_RESET;
      rate      <= `TTC_RESET;
      ctl2      <= `TTC_RESET;
      capl      <= `TTC_RESET;
      caph      <= `TTC_RESET;
      tl2       <= `TTC_RESET;
      th2       <= `TTC_RESET;
      sfr_rdata <= `TTC_RESET;
    end else begin
      ctl01     <= n_ctl01;
      mod01     <= (sfr_wr && sfr_addr == `TTC_A_MODE01) ? sfr_wdata : mod01;
      tl0       <= n_tl0;
      th0       <= n_th0;
      tl1       <= n_tl1;
      th1       <= n_th1;
      rate      <= (sfr_wr && sfr_addr == `TTC_A_RATE) ? sfr_wdata : rate;
      ctl2      <= n_ctl2;
      capl      <= n_capl;
      caph      <= n_caph;
      tl2       <= n_tl2;
      th2       <= n_th2;
      sfr_rdata <= n_rdata;
    end
  end

  // requests to the interrupt controller and bit clocks to the serial port
  assign irq_ext0       = ctl01[`TTC_B_IE0];
  assign irq_ch0        = ctl01[`TTC_B_TF0];
  assign irq_ext1       = ctl01[`TTC_B_IE1];
  assign irq_ch1        = ctl01[`TTC_B_TF1];
  assign irq_ch2        = ctl2[`TTC_B_TF2] | ctl2[`TTC_B_CH2_EXTERNAL_FLAG];
  assign ovf1_tick      = s1[16];
  assign rx_bitclk_tick = ctl2[`TTC_B_RCLK] ? ovf2 : ovf1_tick;
  assign tx_bitclk_tick = ctl2[`TTC_B_TX_BITCLOCK_SELECT] ? ovf2 : ovf1_tick;

endmodule : ttc_unit

/* testbench/testbench.sv */
// self-checking bench of the timer unit
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [3:0] mode; logic [7:0] th, tl; int cyc;} ttc_row_type;
  logic        core_clk = 1'h0, rst = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0, en = 1'h0;
  logic        ext0_n = 1'h1, ext1_n = 1'h1, cnt1 = 1'h1, trg = 1'h1;
  logic        irq_ch2, rx_tick, tx_tick;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d, e;
  logic [3:0]  dly = 4'h0, irq, ack;
  int          num_errors = 0, cmp_count = 0, n, k, n_ack, n_tick;
  ttc_row_type rows [4] = '{'{4'h0, 8'hFF, 8'h10, 64}, '{4'h1, 8'hFF, 8'hF0, 64},
                            '{4'h2, 8'hF0, 8'hF0, 64}, '{4'h3, 8'hFF, 8'hFF, 0}};
  logic [7:0]  regs [9] = '{8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
  ttc_unit i_dut (.core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .ext_irq0_pin(ext0_n), .ext_irq1_pin(ext1_n), .ch0_count_pin(1'h1), .ch1_count_pin(cnt1),
    .ch2_count_pin(1'h1), .ch2_trigger_pin(trg), .ack_ext0(ack[0]), .ack_ch0(ack[1]),
    .ack_ext1(ack[2]), .ack_ch1(ack[3]), .irq_ext0(irq[0]), .irq_ch0(irq[1]), .irq_ext1(irq[2]),
    .irq_ch1(irq[3]), .irq_ch2, .rx_bitclk_tick(rx_tick), .tx_bitclk_tick(tx_tick));
  ttc_core_model i_core (.core_clk, .rst, .en, .dly, .irq, .tick(rx_tick), .ack, .n_ack, .n_tick);
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, v, 1'h1};
    @(negedge core_clk);
    sfr_wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge core_clk);
    {sfr_addr, sfr_rd} = {a, 1'h1};
    @(negedge core_clk);
    sfr_rd = 1'h0;
    v = sfr_rdata;
  endtask : rd
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // cycles until the transmit bit clock pulses, 400 meaning none
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      #1 c++;
    end while (tx_tick !== 1'h1 && c < 400);
  endtask : wait_tick
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // watchdog against a hang
  initial begin
    #100us;
    num_errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'h0;
    foreach (regs[i]) begin
      wr(regs[i], 8'h5A ^ regs[i]);
      rd(regs[i], d);
      chk("readback", 8'h5A ^ regs[i], d);
    end
    wr(8'h8E, 8'hFF);
    rd(8'h8E, d);
    chk("unmapped", 8'h00, d);
    wr(8'h8F, 8'h10);
    foreach (rows[i]) begin
      wr(8'h88, 8'h00);
      wr(8'h89, {rows[i].mode, 4'h0});
      wr(8'h8B, rows[i].tl);
      wr(8'h8D, rows[i].th);
      wr(8'h88, 8'h40);
      wait_tick(n);
      chk("ch1 time", 8'h1, 8'(rows[i].cyc == 0 ? n >= 400 : n > rows[i].cyc - 8 && n < rows[i].cyc + 8));
    end
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h90);
    wr(8'h8B, 8'hF0);
    wr(8'h8D, 8'hFF);
    ext1_n = 1'h0;
    wr(8'h88, 8'h40);
    wait_tick(n);
    chk("gated", 8'h1, 8'(n >= 400));
    ext1_n = 1'h1;
    wait_tick(n);
    chk("ungated", 8'h1, 8'(n > 56 && n < 80));
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h60);
    wr(8'h8B, 8'hFF);
    wr(8'h8D, 8'hFF);
    wr(8'h88, 8'h40);
    k = n_tick;
    repeat (8) begin
      repeat (36) @(negedge core_clk);
      cnt1 = ~cnt1;
    end
    chk("pin counts", 8'h4, 8'(n_tick - k));
    wr(8'h8F, 8'h00);
    wr(8'h89, 8'h02);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'hFE);
    wr(8'h88, 8'h00);
    {en, dly} = {1'h1, 4'h5};
    k = n_ack;
    wr(8'h88, 8'h10);
    repeat (288) @(negedge core_clk);
    wr(8'h88, 8'h00);
    chk("reload count", 8'h1, 8'(n_ack - k > 10 && n_ack - k < 14));
    rd(8'h8A, d);
    repeat (30) @(negedge core_clk);
    rd(8'h8A, e);
    chk("stopped", d, e);
    {en, dly} = {1'h0, 4'h0};
    wr(8'h88, 8'h01);
    ext0_n = 1'h0;
    repeat (6) @(negedge core_clk);
    rd(8'h88, d);
    chk("edge set", 8'h03, d);
    wr(8'h88, 8'h01);
    rd(8'h88, d);
    chk("edge clear", 8'h01, d);
    ext0_n = 1'h1;
    wr(8'h88, 8'h03);
    repeat (6) @(negedge core_clk);
    en = 1'h1;
    repeat (6) @(negedge core_clk);
    en = 1'h0;
    rd(8'h88, d);
    chk("vectored", 8'h01, d);
    wr(8'h88, 8'h00);
    ext0_n = 1'h0;
    repeat (6) @(negedge core_clk);
    wr(8'h88, 8'h00);
    rd(8'h88, d);
    chk("level held", 8'h02, d);
    ext0_n = 1'h1;
    repeat (6) @(negedge core_clk);
    rd(8'h88, d);
    chk("level gone", 8'h00, d);
    wr(8'h89, 8'h03);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h40);
    repeat (30) @(negedge core_clk);
    rd(8'h88, d);
    chk("split flag", 8'hC0, d);
    wr(8'h88, 8'h00);
    wr(8'hCC, 8'h34);
    wr(8'hCD, 8'h12);
    wr(8'hC8, 8'h0D);
    trg = 1'h0;
    repeat (6) @(negedge core_clk);
    trg = 1'h1;
    rd(8'hCB, d);
    chk("capture high", 8'h12, d);
    rd(8'hCA, d);
    chk("capture low", 8'h1, 8'(d >= 8'h34 && d <= 8'h36));
    rd(8'hC8, d);
    chk("external flag", 8'h4D, d);
    wr(8'hC8, 8'h00);
    wr(8'hCA, 8'h00);
    wr(8'hCB, 8'h01);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    repeat (40) @(negedge core_clk);
    rd(8'hCD, d);
    chk("reloaded", 8'h01, d);
    rd(8'hC8, d);
    chk("overflow flag", 8'h84, d);
    wr(8'hC8, 8'h00);
    wr(8'hCA, 8'hF0);
    wr(8'hCB, 8'hFF);
    wr(8'hCC, 8'hF0);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h3C);
    k = n_tick;
    trg = 1'h0;
    repeat (320) @(negedge core_clk);
    trg = 1'h1;
    chk("baud ticks", 8'h1, 8'(n_tick - k > 8 && n_tick - k < 12));
    rd(8'hC8, d);
    chk("baud flags", 8'h7C, d);
    wr(8'hC8, 8'h80);
    chk("forced", 8'h1, {7'h0, irq_ch2});
    rst = 1'h1;
    repeat (2) @(negedge core_clk);
    rst = 1'h0;
    foreach (regs[i]) begin
      rd(regs[i], d);
      chk("reset value", 8'h00, d);
    end
    rd(8'hC8, d);
    chk("reset ctl2", 8'h00, d);
    give_verdict();
  end
endmodule : testbench

/* testbench/ttc_core_model.sv */
// core side model: vectors to pending requests and counts bit clocks
`timescale 1ns/1ps
module ttc_core_model (
  input  wire logic       core_clk, // clock
  input  wire logic       rst,      // reset
  input  wire logic       en,       // vectoring allowed
  input  wire logic [3:0] dly,      // wait before vectoring
  input  wire logic [3:0] irq,      // {ch1, ext1, ch0, ext0}
  input  wire logic       tick,     // bit clock pulse
  output logic      [3:0] ack,      // vector taken pulses
  output int              n_ack,    // vectors taken
  output int              n_tick    // bit clocks seen
);
  logic [3:0] wait_cnt;
  // lowest pending source is vectored after the wait, one pulse at a time
  always @(posedge core_clk) begin
    ack <= 4'h0;
    if (rst) begin
      wait_cnt <= 4'h0;
      n_ack <= 0;
      n_tick <= 0;
    end else begin
      n_tick <= n_tick + int'(tick);
      if (en && |irq && ack == 4'h0 && wait_cnt >= dly) begin
        ack <= irq & (~irq + 4'h1);
        n_ack <= n_ack + 1;
        wait_cnt <= 4'h0;
      end else
        wait_cnt <= (en && |irq) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : ttc_core_model

/* testbench/ttc_unit_monitor.sv */
// checker of the timer unit port behaviour
`timescale 1ns/1ps
`include "ttc_defines.svh"
module ttc_unit_monitor (
  input wire logic       core_clk,       // clock
  input wire logic       rst,            // synchronous reset
  input wire logic [7:0] sfr_addr,       // register address
  input wire logic       sfr_wr,         // write strobe
  input wire logic       sfr_rd,         // read strobe
  input wire logic [7:0] sfr_wdata,      // write data
  input wire logic [7:0] sfr_rdata,      // read data
  input wire logic       ext_irq0_pin,   // external pin 0
  input wire logic       ack_ext0,       // vector taken, external 0
  input wire logic       ack_ch0,        // vector taken, channel 0
  input wire logic       irq_ext0,       // request external 0
  input wire logic       irq_ch0,        // request channel 0
  input wire logic       irq_ch1,        // request channel 1
  input wire logic       irq_ch2,        // request channel 2
  input wire logic       rx_bitclk_tick, // receive bit clock
  input wire logic       tx_bitclk_tick  // transmit bit clock
);
  logic it0;
  logic rclk;
  logic tx_bitclock_select;
  logic [1:0] m0;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // mirror of the edge-type, channel 0 mode and clock-select bits
  always_ff @(posedge core_clk)
    if (rst)
      {it0, rclk, tx_bitclock_select, m0} <= 5'h00;
    else if (sfr_wr && sfr_addr == `TTC_A_MODE01)
      m0 <= sfr_wdata[1:0];
    else if (sfr_wr && sfr_addr == `TTC_A_CTRL01)
      it0 <= sfr_wdata[0];
    else if (sfr_wr && sfr_addr == `TTC_A_CTRL2)
      {rclk, tx_bitclock_select} <= sfr_wdata[5:4];
  sequence lvl_low_s;
    (!it0 && !ext_irq0_pin) [*4];
  endsequence
  sequence lvl_high_s;
    (!it0 && ext_irq0_pin) [*4];
  endsequence
  sequence edge_high_s;
    (it0 && ext_irq0_pin) [*4];
  endsequence
  ack_clear_a: assert property (ack_ch0 && irq_ch0 |=> !irq_ch0)
    else $error("channel 0 flag kept after vector");
  rd_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (sfr_rd && sfr_addr == 8'h8E |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  level_set_a: assert property (lvl_low_s |-> irq_ext0)
    else $error("level request missing");
  level_clear_a: assert property (lvl_high_s |-> !irq_ext0)
    else $error("level request stuck");
  edge_set_a: assert property (it0 && $fell(ext_irq0_pin) |-> ##[1:4] irq_ext0)
    else $error("edge request missing");
  edge_ack_a: assert property (edge_high_s ##0 ack_ext0 |=> !irq_ext0)
    else $error("edge request kept after vector");
  ch2_force_a: assert property (sfr_wr && sfr_addr == `TTC_A_CTRL2 && sfr_wdata[7] |=> irq_ch2)
    else $error("channel 2 request not forced");
  tick_flag_a: assert property (tx_bitclk_tick && !tx_bitclock_select && m0 != 2'h3 |=> irq_ch1)
    else $error("bit clock without channel 1 flag");
  tick_pair_a: assert property (rclk == tx_bitclock_select |-> rx_bitclk_tick == tx_bitclk_tick)
    else $error("bit clocks differ with equal selects");
endmodule : ttc_unit_monitor
bind ttc_unit ttc_unit_monitor i_mon (.core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata, .ext_irq0_pin, .ack_ext0, .ack_ch0, .irq_ext0, .irq_ch0, .irq_ch1, .irq_ch2,
  .rx_bitclk_tick, .tx_bitclk_tick);
